// *** logic/eeprom_protect_ctrl.sv ***
// Protect-register instruction logic of a serial EEPROM, serial side and self-timed side
`include "eeprom_protect_consts.svh"

module eeprom_protect_ctrl #(
   parameter int unsigned WP_TIME_NS = `T_WP_NS
) (
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   input wire logic SERIAL_CLOCK_I,
   input wire logic CS_I,
   input wire logic DI_I,
   input wire logic PROGRAM_ENABLE_PIN_I,
   input wire logic PRE_I,
   input wire logic WRITE_EN_I,
   input wire logic [7:0] WR_ADDR_I,
   output logic DO_O,
   output logic DO_OE_O,
   output logic WR_BLOCKED_O,
   output logic FILL_ALL_OK_O,
   output logic BUSY_O,
   output logic LOCKED_O,
   output logic [7:0] BOUNDARY_O
);

   // Longest time, so the count rounds down, never below one cycle
   localparam int unsigned WP_CYCLES_RAW = (WP_TIME_NS * `CLK_SYS_MHZ) / `NS_PER_US;
   localparam int unsigned WP_CYCLES = (WP_CYCLES_RAW < 1) ? 1 : WP_CYCLES_RAW;

   // ---------------- Serial clock domain ----------------
   logic link_rst_n;
   logic started;
   logic [3:0] bit_cnt;
   logic [9:0] shift_in;
   logic prog_en_all;
   logic pre_all;
   logic read_active;
   logic [8:0] read_sr;
   logic [3:0] read_cnt;
   logic last_edge;
   logic [1:0] frame_op;
   logic [7:0] frame_addr;
   eeprom_protect_pkg::cmd_t cmd_word;
   logic cmd_tgl;
   logic start_tgl;

   // ---------------- System clock domain ----------------
   logic [`SYNC_W-1:0] sync_vec;
   logic [`SYNC_W-1:0] sync_prev;
   logic cs_fall;
   logic cmd_evt;
   logic start_evt;
   eeprom_protect_pkg::cmd_t cmd_hold;
   eeprom_protect_pkg::cmd_t cur_cmd;
   logic pending;
   logic exec;
   logic prot_ok;
   logic is_unlock;
   logic is_clear;
   logic is_write;
   logic is_lock;
   logic start_prog;
   logic timer_done;
   logic unlock;
   logic locked;
   logic cleared;
   logic [7:0] boundary;
   logic [7:0] prog_addr;
   eeprom_protect_pkg::prog_state_t st;
   eeprom_protect_pkg::prog_kind_t prog_kind;
   eeprom_protect_pkg::prog_kind_t next_kind;
   logic status_bit;
   logic show_status;

   // Dropping chip select clears the frame state, so the serial side restarts clean
   assign link_rst_n = CS_I & RSTN_I;

   // Edge that clocks in the final address bit, and the frame fields it completes
   assign last_edge = started && (bit_cnt == `LAST_BIT_IDX);
   assign frame_op = shift_in[8:7];
   assign frame_addr = {shift_in[6:0], DI_I};

   // frame restart
   // Leading zeros are skipped; the first one is the start bit of a frame
   always_ff @(posedge SERIAL_CLOCK_I or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         started <= 1'b0;
         bit_cnt <= 4'h0;
         shift_in <= 10'h000;
         prog_en_all <= 1'b0;
         pre_all <= 1'b0;
      end
      else if (!started)
      begin
         if (DI_I)
         begin
            started <= 1'b1;
            bit_cnt <= 4'h0;
            prog_en_all <= PROGRAM_ENABLE_PIN_I;
            pre_all <= PRE_I;
         end
      end
      else if (bit_cnt != `FRAME_LEN)
      begin
         bit_cnt <= bit_cnt + 4'h1;
         shift_in <= {shift_in[8:0], DI_I};
         prog_en_all <= prog_en_all & PROGRAM_ENABLE_PIN_I;
         pre_all <= pre_all & PRE_I;
      end
   end

   // boundary readback
   // The boundary is read straight from the system side: it only changes at the end
   // of a timed cycle, and the host may not read while a cycle runs, so it is stable
   always_ff @(posedge SERIAL_CLOCK_I or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         read_active <= 1'b0;
         read_sr <= 9'h000;
         read_cnt <= 4'h0;
      end
      else if (last_edge && (frame_op == `OP_READ) && pre_all && PRE_I)
      begin
         read_active <= 1'b1;
         read_sr <= {1'b0, boundary};
         read_cnt <= 4'h1;
      end
      else if (read_active)
      begin
         if (read_cnt == `READ_BITS)
            read_active <= 1'b0;
         else
         begin
            read_sr <= {read_sr[7:0], 1'b0};
            read_cnt <= read_cnt + 4'h1;
         end
      end
   end

   // Command word and event toggles survive chip select, so the system side can
   // still pick them up after the frame has ended
   always_ff @(posedge SERIAL_CLOCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         cmd_word <= '0;
         cmd_tgl <= 1'b0;
         start_tgl <= 1'b0;
      end
      else if (CS_I)
      begin
         if (!started && DI_I)
            start_tgl <= ~start_tgl;
         if (last_edge)
         begin
            cmd_word.op <= frame_op;
            cmd_word.addr <= frame_addr;
            cmd_word.prot_sel <= pre_all & PRE_I;
            cmd_word.pins_ok <= prog_en_all & PROGRAM_ENABLE_PIN_I & pre_all & PRE_I;
            cmd_word.overrun <= 1'b0;
            cmd_tgl <= ~cmd_tgl;
         end
         else if (started && (bit_cnt == `FRAME_LEN) && !cmd_word.overrun)
         begin
            cmd_word.overrun <= 1'b1;
            cmd_tgl <= ~cmd_tgl;
         end
      end
   end

   // float when deselected
   // Enable follows the pin directly so the output lets go as soon as chip select drops
   assign DO_OE_O = CS_I & (read_active | show_status);
   assign DO_O = read_active ? read_sr[8] : status_bit;

   // Chip select and both toggles cross through the agreeing synchroniser
   sync_agree3 #(
      .WIDTH(`SYNC_W)
   ) u_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RSTN_I),
      .async_i({CS_I, cmd_tgl, start_tgl}),
      .agreed_o(sync_vec)
   );

   // Previous synchronised values for edge and toggle detection
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         sync_prev <= '0;
      else
         sync_prev <= sync_vec;
   end

   assign cs_fall = sync_prev[`SYNC_CS] & ~sync_vec[`SYNC_CS];
   assign cmd_evt = sync_prev[`SYNC_CMD] ^ sync_vec[`SYNC_CMD];
   assign start_evt = sync_prev[`SYNC_START] ^ sync_vec[`SYNC_START];

   // The word is held since its toggle left the serial side, so it is safe to copy
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         cmd_hold <= '0;
         pending <= 1'b0;
      end
      else if (cmd_evt)
      begin
         cmd_hold <= cmd_word;
         pending <= 1'b1;
      end
      else if (cs_fall)
         pending <= 1'b0;
   end

   // A toggle arriving with the chip select fall is used at once, not lost
   assign cur_cmd = cmd_evt ? cmd_word : cmd_hold;

   assign exec = cs_fall & (pending | cmd_evt) & (st != eeprom_protect_pkg::ST_PROG);

   // Instruction decode of the completed frame
   always_comb
   begin
      prot_ok = cur_cmd.prot_sel & cur_cmd.pins_ok & ~cur_cmd.overrun;
      is_unlock = (cur_cmd.op == `OP_MISC) && (cur_cmd.addr[7:6] == `ADDR_TOP_UNLOCK);
      is_lock = (cur_cmd.op == `OP_MISC) && (cur_cmd.addr[7:6] == `ADDR_TOP_LOCK);
      is_clear = (cur_cmd.op == `OP_CLEAR);
      is_write = (cur_cmd.op == `OP_WRITE);
      next_kind = eeprom_protect_pkg::PK_CLEAR;
      if (is_write)
         next_kind = eeprom_protect_pkg::PK_WRITE;
      else if (is_lock)
         next_kind = eeprom_protect_pkg::PK_LOCK;
   end

   assign start_prog = exec & prot_ok & unlock & ~locked &
                       (is_clear | is_lock | (is_write & cleared));

   // unlock single use
   // Any executed instruction consumes the unlock; only a valid unlock sets it again
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         unlock <= 1'b0;
      else if (exec)
         unlock <= is_unlock & prot_ok & WRITE_EN_I & ~locked;
   end

   self_timer #(
      .CYCLES(WP_CYCLES)
   ) u_timer (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RSTN_I),
      .start_i(start_prog),
      .done_o(timer_done)
   );

   // cycle ignores polling
   // Chip select activity only reaches this machine through start bits and frames,
   // and both are refused while the cycle runs
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         st <= eeprom_protect_pkg::ST_IDLE;
         prog_kind <= eeprom_protect_pkg::PK_CLEAR;
         prog_addr <= 8'h00;
      end
      else
      begin
         case (st)
            eeprom_protect_pkg::ST_IDLE:
            begin
               if (start_prog)
               begin
                  st <= eeprom_protect_pkg::ST_PROG;
                  prog_kind <= next_kind;
                  prog_addr <= cur_cmd.addr;
               end
            end
            eeprom_protect_pkg::ST_PROG:
            begin
               if (timer_done)
                  st <= eeprom_protect_pkg::ST_READY;
            end
            eeprom_protect_pkg::ST_READY:
            begin
               if (start_prog)
               begin
                  st <= eeprom_protect_pkg::ST_PROG;
                  prog_kind <= next_kind;
                  prog_addr <= cur_cmd.addr;
               end
               else if (start_evt)
                  st <= eeprom_protect_pkg::ST_IDLE;
            end
            default:
               st <= eeprom_protect_pkg::ST_IDLE;
         endcase
      end
   end

   // Boundary, cleared mark and lock change only when a timed cycle completes.
   // Power-up state is volatile here; the cell array behind it is not modelled.
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         boundary <= `BOUNDARY_CLEARED;
         cleared <= 1'b0;
         locked <= 1'b0;
      end
      else if (timer_done)
      begin
         case (prog_kind)
            eeprom_protect_pkg::PK_CLEAR:
            begin
               boundary <= `BOUNDARY_CLEARED;
               cleared <= 1'b1;
            end
            eeprom_protect_pkg::PK_WRITE:
            begin
               boundary <= prog_addr;
               cleared <= 1'b0;
            end
            eeprom_protect_pkg::PK_LOCK:
            begin
               locked <= 1'b1;
            end
            default:
               locked <= locked;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         status_bit <= 1'b0;
         show_status <= 1'b0;
      end
      else
      begin
         status_bit <= (st == eeprom_protect_pkg::ST_READY);
         show_status <= (st != eeprom_protect_pkg::ST_IDLE);
      end
   end

   // Registered views for the memory core and for observation
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         WR_BLOCKED_O <= 1'b0;
         FILL_ALL_OK_O <= 1'b0;
         BUSY_O <= 1'b0;
         LOCKED_O <= 1'b0;
         BOUNDARY_O <= 8'h00;
      end
      else
      begin
         WR_BLOCKED_O <= (WR_ADDR_I >= boundary) && (boundary != `BOUNDARY_CLEARED);
         FILL_ALL_OK_O <= (boundary == `BOUNDARY_CLEARED);
         BUSY_O <= (st == eeprom_protect_pkg::ST_PROG);
         LOCKED_O <= locked;
         BOUNDARY_O <= boundary;
      end
   end

endmodule

// *** include/eeprom_protect_consts.svh ***
// Named constants for the protect-register instruction logic
`ifndef EEPROM_PROTECT_CONSTS_SVH
`define EEPROM_PROTECT_CONSTS_SVH

// Boundary register width and its all-ones cleared value
`define ADDR_W 8
`define BOUNDARY_CLEARED 8'hFF

// Frame layout after the start bit: 2 opcode bits then 8 address bits
`define FRAME_LEN 4'hA
`define LAST_BIT_IDX 4'h9
`define READ_BITS 4'h9

// Opcode encodings, taken with the register-select pin high
`define OP_MISC 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_CLEAR 2'h3

// Top two address bits that split the misc opcode
`define ADDR_TOP_UNLOCK 2'h3
`define ADDR_TOP_LOCK 2'h0

// Self-timed cycle length and clock rate
`define T_WP_NS 10000
`define CLK_SYS_MHZ 200
`define NS_PER_US 1000

// Synchroniser width: chip select, command toggle, start toggle
`define SYNC_W 3
`define SYNC_CS 2
`define SYNC_CMD 1
`define SYNC_START 0

`endif

// *** include/eeprom_protect_pkg.sv ***
// Types shared by the protect-register instruction logic
package eeprom_protect_pkg;

   // Decoded instruction as it crosses from the serial clock domain
   typedef struct packed {
      logic [1:0] op;
      logic [7:0] addr;
      logic prot_sel;
      logic pins_ok;
      logic overrun;
   } cmd_t;

   // Status sequence of the self-timed cycle
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROG,
      ST_READY
   } prog_state_t;

   // Which protect operation the running cycle finishes
   typedef enum logic [1:0] {
      PK_CLEAR,
      PK_WRITE,
      PK_LOCK
   } prog_kind_t;

endpackage

// *** logic/sync_agree3.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
module sync_agree3 #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] agreed_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         // First stage feeds only the second, to contain metastability
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               agreed_o[g] <= 1'b0;
            end
            else
            begin
               s1 <= async_i[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3)
                  agreed_o[g] <= s3;
            end
         end
      end
   endgenerate

endmodule

// *** logic/self_timer.sv ***
// Self-timed cycle counter: a start pulse gives one done pulse CYCLES clocks later
module self_timer #(
   parameter int unsigned CYCLES = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   output logic done_o
);

   localparam logic [31:0] LAST = 32'(CYCLES - 1);

   logic running;
   logic [31:0] count;

   // Restart is not expected while running; the caller blocks it
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         running <= 1'b0;
         count <= 32'h0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            running <= 1'b1;
            count <= 32'h0;
         end
         else if (running)
         begin
            if (count == LAST)
            begin
               running <= 1'b0;
               done_o <= 1'b1;
            end
            else
               count <= count + 32'h1;
         end
      end
   end

endmodule

// *** sim/eeprom_protect_assertions.sv ***
// Port checker for the protect-register instruction logic
module eeprom_protect_assertions #(
   parameter int unsigned WP_TIME_NS = 10000
) (
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   input wire logic CS_I,
   input wire logic [7:0] WR_ADDR_I,
   input wire logic DO_O,
   input wire logic DO_OE_O,
   input wire logic WR_BLOCKED_O,
   input wire logic FILL_ALL_OK_O,
   input wire logic BUSY_O,
   input wire logic LOCKED_O,
   input wire logic [7:0] BOUNDARY_O
);
   localparam int unsigned CYC = WP_TIME_NS * 200 / 1000;
   logic [15:0] run;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   // Length of the current busy stretch; a counter because the cycle is long
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         run <= 16'h0000;
      else
         run <= BUSY_O ? run + 16'h0001 : 16'h0000;
   end
   sequence busy_end_s;
      $fell(BUSY_O);
   endsequence
   sequence late_busy_s;
      $past(BUSY_O) || $past(BUSY_O, 2);
   endsequence
   oe_deselect_a: assert property (!CS_I |-> !DO_OE_O)
      else $error("Output driven while deselected");
   busy_status_a: assert property (BUSY_O && $past(BUSY_O) && CS_I |-> DO_OE_O && !DO_O)
      else $error("Busy status not shown low");
   ready_status_a: assert property (busy_end_s ##1 CS_I |-> DO_OE_O && DO_O)
      else $error("Ready status not shown high");
   busy_length_a: assert property (busy_end_s |-> run inside {[CYC - 1:CYC + 1]})
      else $error("Timed cycle has wrong length");
   lock_at_end_a: assert property ($rose(LOCKED_O) |-> late_busy_s)
      else $error("Lock set outside cycle end");
   lock_sticky_a: assert property (LOCKED_O |=> LOCKED_O)
      else $error("Lock released");
   lock_frozen_a: assert property (LOCKED_O |=> $stable(BOUNDARY_O) && !$rose(BUSY_O))
      else $error("Locked boundary changed or cycle started");
   bound_update_a: assert property ($changed(BOUNDARY_O) && $past(RSTN_I) && $past(RSTN_I, 2) |-> late_busy_s)
      else $error("Boundary changed outside cycle end");
   fill_ok_a: assert property ($past(RSTN_I) && $stable(BOUNDARY_O)
      |-> FILL_ALL_OK_O == (BOUNDARY_O == 8'hFF))
      else $error("Cleared flag disagrees with boundary");
   wr_block_a: assert property ($past(RSTN_I) && $stable(BOUNDARY_O)
      |-> WR_BLOCKED_O == ($past(WR_ADDR_I) >= BOUNDARY_O && BOUNDARY_O != 8'hFF))
      else $error("Write block wrong for address");
endmodule

bind eeprom_protect_ctrl eeprom_protect_assertions #(.WP_TIME_NS(WP_TIME_NS)) chk_inst (
   .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .CS_I(CS_I), .WR_ADDR_I(WR_ADDR_I), .DO_O(DO_O),
   .DO_OE_O(DO_OE_O), .WR_BLOCKED_O(WR_BLOCKED_O), .FILL_ALL_OK_O(FILL_ALL_OK_O), .BUSY_O(BUSY_O),
   .LOCKED_O(LOCKED_O), .BOUNDARY_O(BOUNDARY_O));

// *** sim/eeprom_host.sv ***
// Host model driving serial frames and polling status
module eeprom_host (
   output logic sclk_o,
   output logic cs_o,
   output logic di_o,
   output logic prog_en_o,
   output logic pre_o,
   input wire logic do_i,
   input wire logic do_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Serial clock stands low outside frames
   initial
   begin
      sclk_o = 1'b0;
      cs_o = 1'b0;
      di_o = 1'b0;
      prog_en_o = 1'b1;
      pre_o = 1'b1;
   end
   // One 15 ns serial period, data set while the clock is low
   task automatic bit_out(input logic b);
      begin
         di_o = b;
         #7.5 sclk_o = 1'b1;
         #7.5 sclk_o = 1'b0;
      end
   endtask
   // select drops after the last bit, before any further rise
   task automatic frame(input logic [1:0] op, input logic [7:0] addr, input logic prog_en, output logic [8:0] rd);
      logic [10:0] word;
      begin
         word = {1'b1, op, addr};
         rd = 9'h1FF;
         prog_en_o = prog_en;
         cs_o = 1'b1;
         for (int i = 10; i >= 0; i--)
            bit_out(word[i]);
         // Read frames take the dummy bit and eight data bits
         if (op == 2'h2)
         begin
            for (int j = 8; j >= 0; j--)
            begin
               rd[j] = do_i;
               if (j > 0)
                  bit_out(1'b0);
            end
         end
         cs_o = 1'b0;
         di_o = ~di_o;
         #100;
      end
   endtask
   // nothing issued until ready, polled by select toggles
   task automatic wait_ready(output logic ok);
      begin
         ok = 1'b0;
         for (int n = 0; n < 40 && !ok; n++)
         begin
            cs_o = 1'b1;
            #20;
            ok = (do_oe_i === 1'b1) && (do_i === 1'b1);
            cs_o = 1'b0;
            #40;
         end
      end
   endtask
   // start bit clears status, then select drop resets the frame
   task automatic start_bit(output logic oe);
      begin
         cs_o = 1'b1;
         bit_out(1'b1);
         #60;
         oe = do_oe_i;
         cs_o = 1'b0;
         di_o = ~di_o;
         #60;
      end
   endtask
endmodule

// *** sim/eeprom_protect_ctrl_tb.sv ***
// Self-checking bench for the protect-register instruction logic
module eeprom_protect_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic write_en = 1'b1;
   logic [7:0] wr_addr = 8'h00;
   logic sclk, cs, di, prog_en, pre, do_o, do_oe, blocked, fill_ok, busy, locked, do_line, busy_seen;
   logic [7:0] bound, b, a;
   logic [8:0] rd;
   logic [8:0] exp_q[$];
   int failures = 0;
   int n_checks = 0;
   always #2.5 clk = ~clk;
   // Undriven line toggles so a float never reads as a steady level
   assign do_line = do_oe ? do_o : ~clk;
   eeprom_protect_ctrl #(.WP_TIME_NS(200)) eeprom_protect_ctrl_inst (.CLK_SYS_I(clk), .RSTN_I(rstn),
      .SERIAL_CLOCK_I(sclk), .CS_I(cs), .DI_I(di), .PROGRAM_ENABLE_PIN_I(prog_en), .PRE_I(pre),
      .WRITE_EN_I(write_en), .WR_ADDR_I(wr_addr),
      .DO_O(do_o), .DO_OE_O(do_oe), .WR_BLOCKED_O(blocked), .FILL_ALL_OK_O(fill_ok), .BUSY_O(busy),
      .LOCKED_O(locked), .BOUNDARY_O(bound));
   eeprom_host eeprom_host_inst (.sclk_o(sclk), .cs_o(cs), .di_o(di), .prog_en_o(prog_en), .pre_o(pre), .do_i(do_line),
      .do_oe_i(do_oe));
   task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
      begin
         n_checks++;
         if (got !== exp)
         begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      begin
         chk9({8'h00, got}, {8'h00, exp});
      end
   endtask
   task automatic test_done;
      begin
         if (failures == 0 && n_checks > 0 && exp_q.size() == 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Busy seen flag, and the noted result compared once a timed cycle ends
   always @(posedge busy) busy_seen = 1'b1;
   always @(negedge busy)
   begin
      repeat (2) @(posedge clk);
      #1;
      if (rstn === 1'b1 && exp_q.size() == 0)
         chk1(1'b1, 1'b0);
      else if (rstn === 1'b1)
         chk9({locked, bound}, exp_q.pop_front());
   end
   // Frame then check whether a timed cycle ran; refusals show no busy
   task automatic op(input logic [1:0] code, input logic [7:0] ad, input logic pins, input logic run,
                     input logic [8:0] exp);
      logic ok;
      logic oe;
      begin
         busy_seen = 1'b0;
         if (run)
            exp_q.push_back(exp);
         eeprom_host_inst.frame(code, ad, pins, rd);
         chk1(busy_seen, run);
         if (run)
         begin
            eeprom_host_inst.wait_ready(ok);
            if (!ok)
            begin
               failures++;
               test_done();
            end
            eeprom_host_inst.start_bit(oe);
            chk1(oe, 1'b0);
         end
      end
   endtask
   // Memory-side address probe, one cycle of latency
   task automatic wr(input logic [7:0] ad, input logic exp);
      begin
         @(posedge clk);
         #1 wr_addr = ad;
         repeat (2) @(posedge clk);
         #1 chk1(blocked, exp);
      end
   endtask
   initial
   begin
      #300000;
      failures++;
      test_done();
   end
   // Opcodes: 3 clear, 1 write, 2 read, 0 with C0 unlock or 00 lock
   initial
   begin
      void'($urandom(86));
      b = 8'($urandom_range(1, 253));
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (8) @(posedge clk);
      #1 chk9({locked, bound}, 9'h0FF);
      op(2'h3, 8'h00, 1'b1, 1'b0, 9'h000);
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h1, b, 1'b1, 1'b0, 9'h000);
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h3, 8'h5A, 1'b1, 1'b1, 9'h0FF);
      wr(8'hFF, 1'b0);
      // Unlock refused while the memory core is write-disabled
      @(posedge clk);
      #1 write_en = 1'b0;
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      @(posedge clk);
      #1 write_en = 1'b1;
      op(2'h3, 8'h00, 1'b1, 1'b0, 9'h000);
      // Register-select pin low refuses a clear even after a valid unlock
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      eeprom_host_inst.pre_o = 1'b0;
      op(2'h3, 8'h00, 1'b1, 1'b0, 9'h000);
      eeprom_host_inst.pre_o = 1'b1;
      op(2'h0, 8'hC0, 1'b0, 1'b0, 9'h000);
      op(2'h3, 8'h00, 1'b1, 1'b0, 9'h000);
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h2, 8'h00, 1'b1, 1'b0, 9'h000);
      chk9(rd, 9'h0FF);
      op(2'h1, b, 1'b1, 1'b0, 9'h000);
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h1, b, 1'b1, 1'b1, {1'b0, b});
      wr(b, 1'b1);
      wr(b - 8'h01, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         a = 8'($urandom);
         wr(a, a >= b);
      end
      op(2'h2, 8'h00, 1'b1, 1'b0, 9'h000);
      chk9(rd, {1'b0, b});
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h1, b, 1'b1, 1'b0, 9'h000);
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h0, 8'h00, 1'b1, 1'b1, {1'b1, b});
      op(2'h0, 8'hC0, 1'b1, 1'b0, 9'h000);
      op(2'h3, 8'h00, 1'b1, 1'b0, 9'h000);
      chk9({locked, bound}, {1'b1, b});
      test_done();
   end
endmodule
